// ==== dv/psbpc_sb_model.sv ====
// South-bridge stand-in that drives the sideband and power pins.
`timescale 1ns/1ps
`default_nettype none
module psbpc_sb_model #(
  parameter int PWROK_DLY = 5
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [9:0] ev,
  input  wire logic       rail_ok,
  input  wire logic       irq_ack,
  output logic      [9:0] pins
);
  int cnt;
  // Pins move on the falling edge so the block samples them settled.
  always_ff @(negedge clock)
  begin
    if (!rst_n)
    begin
      pins <= 10'h0F3;
      cnt <= 0;
    end
    else
    begin
      pins[0] <= !ev[0];
      pins[1] <= !ev[1];
      pins[2] <= ev[2] | (pins[2] & !irq_ack);
      pins[3] <= ev[3] | ev[4];
      pins[4] <= !ev[5];
      pins[5] <= !ev[6];
      pins[6] <= !ev[7];
      pins[7] <= !ev[8];
      pins[8] <= ev[9];
      cnt <= rail_ok ? cnt + int'(cnt < PWROK_DLY) : 0;
      pins[9] <= rail_ok && cnt >= PWROK_DLY;
    end
  end
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the sideband and power control block.
`include "psbpc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import psbpc_pkg::*;
  localparam int VR = 8;
  typedef struct packed {logic [9:0] p; logic f, pl, tr, scl, sda; psbpc_addr_t a;} psbpc_hist_t;
  psbpc_hist_t h [4];
  logic clock, rst_n, cpu_fp_error, sensor_dat_pull_low, sensor_trip_event;
  logic scl_drv, dat_drv, rail_ok, chk;
  logic [9:0] ev, pins;
  psbpc_addr_t cpu_addr_in, cpu_addr_out;
  logic fp_error_out_n, cpu_ignore_err_n, cpu_init_n, cpu_irq, cpu_nmi, cpu_smi_n;
  logic quick_start, host_clk_stopped, vr_core_on, power_ok_seen;
  logic regulator_good_out, regulator_good_oe, sensor_serial_clk_out, sensor_serial_clk_oe;
  logic sensor_serial_dat_out, sensor_serial_dat_oe, sensor_clk_seen, sensor_dat_seen;
  logic thermal_trip_out, thermal_trip_oe;
  // Each serial line is a wired AND: it reads low when the block pulls it or the bench drives it low.
  wire scl_line = scl_drv & !sensor_serial_clk_oe;
  wire sda_line = dat_drv & !sensor_serial_dat_oe;
  int seed = 18545, num_errors = 0, num_checks = 0, n, vr_run = 0;

  psbpc_sb_model psbpc_sb_model_inst (.clock, .rst_n, .ev, .rail_ok, .irq_ack(cpu_irq), .pins);

  psbpc_top #(.VR_SETTLE_CYC(VR)) psbpc_top_inst (
    .clock, .rst_n, .cpu_fp_error, .fp_error_out_n,
    .ignore_numeric_err_n(pins[0]), .init_req_n(pins[1]), .maskable_irq(pins[2]),
    .nmi_req(pins[3]), .addr_bit_mask_n(pins[4]), .sys_mgmt_irq_n(pins[5]),
    .stop_clock_req_n(pins[6]), .suspend_status_n(pins[7]),
    .regulator_enable(pins[8]), .power_ok(pins[9]),
    .cpu_ignore_err_n, .cpu_init_n, .cpu_irq, .cpu_nmi, .cpu_smi_n,
    .cpu_addr_in, .cpu_addr_out, .quick_start, .host_clk_stopped, .vr_core_on,
    .power_ok_seen, .regulator_good_out, .regulator_good_oe,
    .sensor_serial_clk_in(scl_line), .sensor_serial_clk_out, .sensor_serial_clk_oe,
    .sensor_serial_dat_in(sda_line), .sensor_serial_dat_out, .sensor_serial_dat_oe,
    .sensor_dat_pull_low, .sensor_clk_seen, .sensor_dat_seen,
    .sensor_trip_event, .thermal_trip_out, .thermal_trip_oe
  );

  function automatic psbpc_addr_t masked(psbpc_addr_t a, logic m);
    a[`PSBPC_A20_BIT] = a[`PSBPC_A20_BIT] & m;
    return a;
  endfunction

  task automatic check(logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("Checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Counts falling edges until the regulator-good level reaches v.
  task automatic wait_rg(logic v, int lim);
    n = 0;
    while (regulator_good_out !== v && n < lim)
    begin
      @(negedge clock);
      n++;
    end
    if (regulator_good_out !== v)
    begin
      num_errors++;
      $display("ERROR at %0t: regulator good wait timed out", $time);
      complete_run();
    end
  endtask

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Pins are captured where the block samples them.
  always @(posedge clock)
  begin
    for (int i = 3; i > 0; i--)
      h[i] = h[i-1];
    h[0] = {pins, cpu_fp_error, sensor_dat_pull_low, sensor_trip_event, scl_line, sda_line,
            cpu_addr_in};
  end

  always @(negedge clock)
    if (chk)
    begin
      // Good needs an unbroken run of enable samples one longer than the settle count.
      vr_run = h[2].p[8] ? vr_run + 1 : 0;
      check(fp_error_out_n, !h[0].f);
      check(cpu_ignore_err_n, h[2].p[0]);
      check(cpu_init_n, h[2].p[1]);
      check(cpu_irq, h[2].p[2]);
      check(cpu_nmi, h[2].p[3]);
      check(cpu_addr_out, masked(h[0].a, h[2].p[4]));
      check(cpu_smi_n, h[2].p[5]);
      check(quick_start, !h[2].p[6]);
      check(host_clk_stopped, !h[2].p[7]);
      check(vr_core_on, h[2].p[8]);
      check(power_ok_seen, h[2].p[9]);
      check({regulator_good_out, regulator_good_oe}, {2{vr_run > VR}});
      check({sensor_serial_clk_out, sensor_serial_clk_oe, sensor_serial_dat_out,
             sensor_serial_dat_oe}, {3'h0, h[0].pl});
      check({sensor_clk_seen, sensor_dat_seen}, {h[1].scl, h[1].sda});
      check({thermal_trip_out, thermal_trip_oe}, {1'h0, h[0].tr});
    end

  initial
  begin
    {rst_n, cpu_fp_error, sensor_dat_pull_low, sensor_trip_event} = 4'h0;
    {scl_drv, dat_drv, rail_ok, chk} = 4'h0;
    ev = 10'h000;
    cpu_addr_in = 32'h00000000;
    repeat (2) @(negedge clock);
    rst_n <= 1'b1;
    repeat (5) @(negedge clock);
    chk = 1'b1;
    repeat (3000)
    begin
      @(negedge clock);
      if ($random(seed) % 4 == 0)
        ev[8:0] <= 9'($random(seed));
      cpu_addr_in <= 32'($random(seed));
      {cpu_fp_error, sensor_dat_pull_low, sensor_trip_event, scl_drv, dat_drv} <= 5'($random(seed));
      rail_ok <= ($random(seed) % 32) != 0;
    end
    $display("Random pin traffic done");
    // A reset in mid-run must bring every output except the constant-low serial clock, data-out and trip-out drives back to its idle level.
    chk = 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(negedge clock);
    check({fp_error_out_n, cpu_ignore_err_n, cpu_init_n, cpu_irq, cpu_nmi, cpu_smi_n,
           quick_start, host_clk_stopped, vr_core_on, power_ok_seen, regulator_good_out,
           regulator_good_oe, thermal_trip_oe, sensor_serial_dat_oe, sensor_clk_seen,
           sensor_dat_seen}, 16'hE403);
    check(cpu_addr_out, 32'h00000000);
    rst_n <= 1'b1;
    repeat (5) @(negedge clock);
    chk = 1'b1;
    $display("Mid-run reset test done");
    // Stop request and address mask held while the other events, except suspend and regulator enable, keep moving.
    repeat (40)
    begin
      @(negedge clock);
      ev <= 10'h0A0 | (10'($random(seed)) & 10'h05F);
      cpu_addr_in <= 32'($random(seed)) | 32'h00100000;
    end
    ev <= 10'h000;
    repeat (6) @(negedge clock);
    $display("Held stop and mask test done");
    ev[9] <= 1'b1;
    wait_rg(1'b1, 60);
    check(n >= VR + 2 && n <= VR + 8, 1'b1);
    ev[9] <= 1'b0;
    wait_rg(1'b0, 10);
    check(n <= 6, 1'b1);
    // An enable pulse shorter than the settle time must never report good.
    ev[9] <= 1'b1;
    repeat (VR / 2) @(negedge clock);
    ev[9] <= 1'b0;
    repeat (2 * VR) @(negedge clock) check(regulator_good_out, 1'b0);
    ev[9] <= 1'b1;
    wait_rg(1'b1, 60);
    check(n >= VR + 2 && n <= VR + 8, 1'b1);
    $display("Regulator settle test done");
    complete_run();
  end
endmodule
`default_nettype wire

// ==== verilog/psbpc_cfg.svh ====
// Constants for the processor sideband and power control block.
`ifndef PSBPC_CFG_SVH
`define PSBPC_CFG_SVH

`define PSBPC_CLK_PERIOD_NS   10
`define PSBPC_VR_SETTLE_NS    10000
`define PSBPC_VR_SETTLE_CYC   (`PSBPC_VR_SETTLE_NS / `PSBPC_CLK_PERIOD_NS)
`define PSBPC_A20_BIT         20
`define PSBPC_ADDR_W          32
`define PSBPC_PIN_W           12
`define PSBPC_PIN_RST         12'hCF3
`define PSBPC_SIDE_RST        5'h19
`define PSBPC_SYNC_STAGES     3
`define PSBPC_PIN_IGNORE_NUMERIC_ERR_N       11
`define PSBPC_PIN_INIT        10
`define PSBPC_PIN_IRQ         9
`define PSBPC_PIN_NMI         8
`define PSBPC_PIN_ADDR_BIT_MASK_N        7
`define PSBPC_PIN_SMI         6
`define PSBPC_PIN_STOP        5
`define PSBPC_PIN_SUS         4
`define PSBPC_PIN_VREN        3
`define PSBPC_PIN_PWROK       2
`define PSBPC_PIN_SCL         1
`define PSBPC_PIN_SDA         0

`endif

// ==== verilog/psbpc_pkg.sv ====
// Types shared by the processor sideband and power control block.
`include "psbpc_cfg.svh"
`default_nettype none
package psbpc_pkg;
  typedef logic [`PSBPC_ADDR_W-1:0] psbpc_addr_t;
  typedef enum logic {PSBPC_RUN, PSBPC_QUICK_START} psbpc_qs_state_t;
endpackage
`default_nettype wire

// ==== verilog/psbpc_sync.sv ====
// Two-flop synchroniser for a vector of independent pin levels.
`timescale 1ns/1ps
`default_nettype none
module psbpc_sync #(
  parameter int           W         = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input  wire logic   clock,
  input  wire logic   rst_n,
  psbpc_sync_if.dst   pins
);
  import psbpc_pkg::*;

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // Each bit is an unrelated level, so no coherence between bits is promised.
  always_comb
  begin
    meta_d = pins.raw;
    sync_d = meta_q;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign pins.sync = sync_q;
endmodule
`default_nettype wire

// ==== verilog/psbpc_sync_if.sv ====
// Raw and synchronised pin vectors between the top and its synchroniser.
`timescale 1ns/1ps
`default_nettype none
interface psbpc_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport src (output raw, input sync);
  modport dst (input raw, output sync);
endinterface
`default_nettype wire

// ==== verilog/psbpc_top.sv ====
// Sideband and power control logic between the processor core and the south bridge.
`include "psbpc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module psbpc_top #(
  parameter int VR_SETTLE_CYC = `PSBPC_VR_SETTLE_CYC
) (
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire logic               cpu_fp_error,
  output logic                    fp_error_out_n,
  input  wire logic               ignore_numeric_err_n,
  input  wire logic               init_req_n,
  input  wire logic               maskable_irq,
  input  wire logic               nmi_req,
  input  wire logic               addr_bit_mask_n,
  input  wire logic               sys_mgmt_irq_n,
  input  wire logic               stop_clock_req_n,
  input  wire logic               suspend_status_n,
  input  wire logic               regulator_enable,
  input  wire logic               power_ok,
  output logic                    cpu_ignore_err_n,
  output logic                    cpu_init_n,
  output logic                    cpu_irq,
  output logic                    cpu_nmi,
  output logic                    cpu_smi_n,
  input  wire psbpc_pkg::psbpc_addr_t cpu_addr_in,
  output psbpc_pkg::psbpc_addr_t  cpu_addr_out,
  output logic                    quick_start,
  output logic                    host_clk_stopped,
  output logic                    vr_core_on,
  output logic                    power_ok_seen,
  output logic                    regulator_good_out,
  output logic                    regulator_good_oe,
  input  wire logic               sensor_serial_clk_in,
  output logic                    sensor_serial_clk_out,
  output logic                    sensor_serial_clk_oe,
  input  wire logic               sensor_serial_dat_in,
  output logic                    sensor_serial_dat_out,
  output logic                    sensor_serial_dat_oe,
  input  wire logic               sensor_dat_pull_low,
  output logic                    sensor_clk_seen,
  output logic                    sensor_dat_seen,
  input  wire logic               sensor_trip_event,
  output logic                    thermal_trip_out,
  output logic                    thermal_trip_oe
);
  import psbpc_pkg::*;

  localparam int CNT_W = $clog2(VR_SETTLE_CYC + 1);

  psbpc_sync_if #(.W(`PSBPC_PIN_W)) pin_bus ();

  assign pin_bus.raw = {ignore_numeric_err_n, init_req_n, maskable_irq, nmi_req,
                        addr_bit_mask_n, sys_mgmt_irq_n, stop_clock_req_n,
                        suspend_status_n, regulator_enable, power_ok,
                        sensor_serial_clk_in, sensor_serial_dat_in};

  psbpc_sync #(
    .W         (`PSBPC_PIN_W),
    .RESET_VAL (`PSBPC_PIN_RST)
  ) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .pins  (pin_bus)
  );

  logic [`PSBPC_PIN_W-1:0] s;
  assign s = pin_bus.sync;

  // Pass-through sideband levels, each registered once; the pin levels after synchronising, the rest directly.
  logic        fp_err_q, fp_err_d;
  logic [4:0]  side_q, side_d;
  logic [3:0]  pm_q, pm_d;
  psbpc_addr_t addr_q, addr_d;
  logic        trip_q, trip_d;
  logic        dat_oe_q, dat_oe_d;

  always_comb
  begin
    fp_err_d = ~cpu_fp_error;
    side_d   = {s[`PSBPC_PIN_IGNORE_NUMERIC_ERR_N],
                s[`PSBPC_PIN_INIT],
                s[`PSBPC_PIN_IRQ],
                s[`PSBPC_PIN_NMI],
                s[`PSBPC_PIN_SMI]};
    pm_d     = {~s[`PSBPC_PIN_SUS],
                s[`PSBPC_PIN_VREN],
                s[`PSBPC_PIN_PWROK],
                1'b0};
    addr_d   = cpu_addr_in;
    // The mask pin is sampled once, so a slow edge never splits an address.
    addr_d[`PSBPC_A20_BIT] = cpu_addr_in[`PSBPC_A20_BIT] & s[`PSBPC_PIN_ADDR_BIT_MASK_N];
    trip_d   = sensor_trip_event;
    dat_oe_d = sensor_dat_pull_low;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      fp_err_q <= 1'b1;
      side_q   <= `PSBPC_SIDE_RST;
      pm_q     <= '0;
      addr_q   <= '0;
      trip_q   <= 1'b0;
      dat_oe_q <= 1'b0;
    end
    else
    begin
      fp_err_q <= fp_err_d;
      side_q   <= side_d;
      pm_q     <= pm_d;
      addr_q   <= addr_d;
      trip_q   <= trip_d;
      dat_oe_q <= dat_oe_d;
    end
  end

  // Quick-start state follows the synchronised stop-clock request.
  psbpc_qs_state_t qs_q, qs_d;

  always_comb
  begin
    qs_d = qs_q;
    unique case (qs_q)
      PSBPC_RUN:
        if (!s[`PSBPC_PIN_STOP])
          qs_d = PSBPC_QUICK_START;
      PSBPC_QUICK_START:
        if (s[`PSBPC_PIN_STOP])
          qs_d = PSBPC_RUN;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      qs_q <= PSBPC_RUN;
    else
      qs_q <= qs_d;
  end

  // Regulator good waits out a settle time; it restarts on every enable drop.
  logic [CNT_W-1:0] vr_cnt_q, vr_cnt_d;
  logic             vr_good_q, vr_good_d;

  always_comb
  begin
    vr_cnt_d  = vr_cnt_q;
    vr_good_d = vr_good_q;
    if (!s[`PSBPC_PIN_VREN])
    begin
      vr_cnt_d  = '0;
      vr_good_d = 1'b0;
    end
    else if (vr_cnt_q != CNT_W'(VR_SETTLE_CYC))
      vr_cnt_d = vr_cnt_q + CNT_W'(1);
    else
      vr_good_d = 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      vr_cnt_q  <= '0;
      vr_good_q <= 1'b0;
    end
    else
    begin
      vr_cnt_q  <= vr_cnt_d;
      vr_good_q <= vr_good_d;
    end
  end

  assign fp_error_out_n        = fp_err_q;
  assign {cpu_ignore_err_n, cpu_init_n, cpu_irq, cpu_nmi, cpu_smi_n} = side_q;
  assign host_clk_stopped      = pm_q[3];
  assign vr_core_on            = pm_q[2];
  assign power_ok_seen         = pm_q[1];
  assign cpu_addr_out          = addr_q;
  assign quick_start           = (qs_q == PSBPC_QUICK_START);
  assign regulator_good_out    = vr_good_q;
  assign regulator_good_oe     = vr_good_q;
  // The sensor is a slave on the serial link: it never drives the clock.
  assign sensor_serial_clk_out = pm_q[0];
  assign sensor_serial_clk_oe  = pm_q[0];
  assign sensor_serial_dat_out = pm_q[0];
  assign sensor_serial_dat_oe  = dat_oe_q;
  assign sensor_clk_seen       = s[`PSBPC_PIN_SCL];
  assign sensor_dat_seen       = s[`PSBPC_PIN_SDA];
  assign thermal_trip_out      = pm_q[0];
  assign thermal_trip_oe       = trip_q;

  // Checks; a reset history keeps the pin checks quiet until the synchroniser has refilled.
  logic [3:0] rst_hist_q;
  always_ff @(posedge clock)
  begin
    rst_hist_q <= {rst_hist_q[2:0], rst_n};
  end
  logic settled;
  assign settled = &rst_hist_q & rst_n;

  property p_fp_err;
    @(posedge clock) disable iff (!rst_n)
      rst_hist_q[0] |-> fp_error_out_n == !$past(cpu_fp_error);
  endproperty
  a_fp_err: assert property (p_fp_err) else $error("fp error output mismatch");

  property p_ignore;
    @(posedge clock) disable iff (!rst_n)
      settled |-> cpu_ignore_err_n == $past(ignore_numeric_err_n, 3);
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignore-error not routed");

  property p_smi;
    @(posedge clock) disable iff (!rst_n)
      settled |-> cpu_smi_n == $past(sys_mgmt_irq_n, 3);
  endproperty
  a_smi: assert property (p_smi) else $error("management interrupt not routed");

  property p_a20;
    @(posedge clock) disable iff (!rst_n)
      (settled && !$past(addr_bit_mask_n, 3)) |-> !cpu_addr_out[`PSBPC_A20_BIT];
  endproperty
  a_a20: assert property (p_a20) else $error("address bit not forced low");

  property p_qs_enter;
    @(posedge clock) disable iff (!rst_n)
      (settled && !$past(stop_clock_req_n, 3)) |-> quick_start;
  endproperty
  a_qs_enter: assert property (p_qs_enter) else $error("quick-start not entered");

  property p_qs_exit;
    @(posedge clock) disable iff (!rst_n)
      (settled && $fell(quick_start)) |-> $past(stop_clock_req_n, 3);
  endproperty
  a_qs_exit: assert property (p_qs_exit) else $error("quick-start left early");

  property p_vr_good;
    @(posedge clock) disable iff (!rst_n)
      $rose(regulator_good_oe) |-> $past(vr_cnt_q) == CNT_W'(VR_SETTLE_CYC);
  endproperty
  a_vr_good: assert property (p_vr_good) else $error("regulator good too soon");

  property p_vr_off;
    @(posedge clock) disable iff (!rst_n)
      (settled && !$past(regulator_enable, 3)) |-> !regulator_good_oe && vr_cnt_q == '0;
  endproperty
  a_vr_off: assert property (p_vr_off) else $error("regulator good while off");

  property p_trip;
    @(posedge clock) disable iff (!rst_n)
      rst_hist_q[0] |-> thermal_trip_oe == $past(sensor_trip_event) && !thermal_trip_out;
  endproperty
  a_trip: assert property (p_trip) else $error("thermal trip not driven");
endmodule
`default_nettype wire
